// ### hw/gwic_top.sv
// Wake and interrupt configuration for external lines on pins 4 to 7.
//
// The Avalon-MM register port is this design's own decision.
`include "gwic_defines.svh"

// Contract
// - Config register at 0xa24 resets to zero: lines disabled, rising mode.
// - Bit 15 enables line 7; matching pin 7 activity flags and wakes.
// - Bits 14:12 hold line 7 trigger mode applied to pin 7.
// - Bit 11 enables line 6; matching pin 6 activity flags and wakes.
// - Bits 10:8 hold line 6 trigger mode for pin 6.
// - Bit 7 enables line 5; matching pin 5 activity flags and wakes.
// - Bits 6:4 hold line 5 trigger mode for pin 5.
// - Bit 3 enables line 4; matching pin 4 activity flags and wakes.
// - Bits 2:0 hold line 4 trigger mode for pin 4.
// - Modes 000 rise, 001 fall, 010 either, 011 high, 100 low.
// - Codes 101, 110, 111 alias fall, either edge and high.
// - A disabled line never raises a flag nor wakes the device.
// - Writing one to a clear bit drops the flag; clear bit self-clears.
module gwic_top
  import gwic_pkg::*;
#(
  parameter int NUM_LINES = `GWIC_NUM_LINES
)
(
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic [11:0]          avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [3:0]           avs_byteenable_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic      [31:0]          avs_readdata_out,
  output logic                      avs_waitrequest_out,
  input  wire logic [NUM_LINES-1:0] gpio_pins_in,
  output logic      [NUM_LINES-1:0] line_flags_out,
  output logic                      wake_out,
  output logic                      irq_out
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  gwic_av_req_s          req;
  logic [`GWIC_CFG_W-1:0] cfg;
  logic [`GWIC_CFG_W-1:0] next_cfg;
  logic [NUM_LINES-1:0]  flags;
  logic [NUM_LINES-1:0]  mask;
  logic [NUM_LINES-1:0]  hits;
  logic [NUM_LINES-1:0]  clr_bits;
  logic [NUM_LINES-1:0]  line_en;
  logic [NUM_LINES-1:0]  next_line_en;
  logic [NUM_LINES-1:0]  next_flags;
  logic                  accept;
  logic                  wr_cfg;
  logic                  wr_clr;
  logic                  wr_stat;
  logic                  wr_mask;
  logic [31:0]           next_readdata;

  assign req.read       = avs_read_in;
  assign req.write      = avs_write_in;
  assign req.address    = avs_address_in;
  assign req.byteenable = avs_byteenable_in;
  assign req.writedata  = avs_writedata_in;

  // ----------------------------------------------------------------------
  // Per-line detectors
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LINES; gi++)
    begin : g_line
      gwic_line_cfg_s lcfg;

      assign lcfg.enable = cfg[gi*`GWIC_FIELD_W + `GWIC_EN_OFS];
      assign lcfg.mode   = cfg[gi*`GWIC_FIELD_W +: `GWIC_MODE_W];
      assign line_en[gi] = lcfg.enable;
      assign next_line_en[gi] = next_cfg[gi*`GWIC_FIELD_W + `GWIC_EN_OFS];

      gwic_line_detect u_detect (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .pin_in     (gpio_pins_in[gi]),
        .cfg_in     (lcfg),
        .hit_out    (hits[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Avalon slave
  // ----------------------------------------------------------------------
  // A request is answered one cycle after it is seen, so waitrequest
  // falls for exactly one cycle and the access completes on that edge.
  assign accept  = (req.read | req.write) & ~avs_waitrequest_out;
  assign wr_cfg  = accept & req.write & (req.address == `GWIC_ADDR_CFG);
  assign wr_clr  = accept & req.write & (req.address == `GWIC_ADDR_CLR)
                   & req.byteenable[0];
  assign wr_stat = accept & req.write & (req.address == `GWIC_ADDR_STAT)
                   & req.byteenable[0];
  assign wr_mask = accept & req.write & (req.address == `GWIC_ADDR_MASK)
                   & req.byteenable[0];

  // Both the clear register and the status register drop flags.
  assign clr_bits =
    (wr_clr ? req.writedata[`GWIC_CLR_LSB +: NUM_LINES] : '0) |
    (wr_stat ? req.writedata[NUM_LINES-1:0] : '0);

  always_comb
  begin
    next_readdata = `GWIC_RD_ZERO;
    case (req.address)
      `GWIC_ADDR_CFG:  next_readdata[`GWIC_CFG_W-1:0] = cfg;
      `GWIC_ADDR_STAT: next_readdata[NUM_LINES-1:0] = flags;
      `GWIC_ADDR_MASK: next_readdata[NUM_LINES-1:0] = mask;
      // Clear bits self-clear, so they always read back as zero.
      `GWIC_ADDR_CLR:  next_readdata = `GWIC_RD_ZERO;
      default:         next_readdata = `GWIC_RD_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      avs_waitrequest_out <= 1'b1;
    end
    else if ((req.read | req.write) && avs_waitrequest_out)
    begin
      avs_waitrequest_out <= 1'b0;
    end
    else
    begin
      avs_waitrequest_out <= 1'b1;
    end
  end

  // Read data holds until the next answer replaces it.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      avs_readdata_out <= `GWIC_RD_ZERO;
    end
    else if ((req.read | req.write) && avs_waitrequest_out)
    begin
      avs_readdata_out <= next_readdata;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration and mask registers
  // ----------------------------------------------------------------------
  // The enables of the value being written are needed in the same cycle,
  // so that a line switched off cannot leave a flag or a wake behind.
  always_comb
  begin
    next_cfg = cfg;
    if (wr_cfg)
    begin
      if (req.byteenable[0])
      begin
        next_cfg[7:0] = req.writedata[7:0];
      end
      if (req.byteenable[1])
      begin
        next_cfg[15:8] = req.writedata[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      cfg <= `GWIC_CFG_RST;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      mask <= `GWIC_MASK_RST;
    end
    else if (wr_mask)
    begin
      mask <= req.writedata[NUM_LINES-1:0];
    end
  end

  // ----------------------------------------------------------------------
  // Flags, wake and interrupt
  // ----------------------------------------------------------------------
  // A hit in the same cycle as a clear keeps the flag set. A line that is
  // switched off drops its flag so it can no longer hold the wake request.
  assign next_flags =
    ((flags & ~clr_bits) | hits) & next_line_en;

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      flags <= `GWIC_FLAG_RST;
    end
    else
    begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      line_flags_out <= `GWIC_FLAG_RST;
    end
    else
    begin
      line_flags_out <= next_flags;
    end
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      wake_out <= 1'b0;
    end
    else
    begin
      wake_out <= |next_flags;
    end
  end

  // A new mask acts one cycle after its write: the interrupt is built from
  // the mask that stood before the edge.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      irq_out <= 1'b0;
    end
    else
    begin
      irq_out <= |(next_flags & mask);
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_cfg_reset_zero: assert property ($past(!rst_n_in) |-> cfg == '0)
    else $error("Configuration not zero after reset.");
  a_cfg_write_full: assert property (
    wr_cfg && req.byteenable[1:0] == 2'h3
      |=> cfg == $past(req.writedata[15:0]))
    else $error("Configuration write not stored.");
  a_hit_sets_flag: assert property (
    |hits |=> (flags & $past(hits) & line_en) == ($past(hits) & line_en))
    else $error("Hit did not set its flag.");
  a_clear_drops_flag: assert property (
    wr_clr |=> (flags & $past(req.writedata[7:4]) & ~$past(hits)) == '0)
    else $error("Clear bit did not drop the flag.");
  a_disabled_no_flag: assert property ((flags & ~line_en) == '0)
    else $error("Flag held on a disabled line.");
  a_wake_follows: assert property (
    |hits ##1 |($past(hits) & line_en)
      |-> wake_out ##1 (wake_out || $past(wr_clr || wr_stat || wr_cfg)))
    else $error("Wake did not follow a hit.");
  a_irq_masked: assert property (
    (flags & mask) == '0 && (hits & mask) == '0 ##1 $stable(mask)
      |-> !irq_out)
    else $error("Interrupt raised with no unmasked flag.");
  a_bus_answer: assert property (
    (req.read || req.write) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
    else $error("Bus answer not a one-cycle waitrequest low.");
  a_stat_w1c: assert property (
    wr_stat |=> (flags & $past(req.writedata[3:0]) & ~$past(hits)) == '0)
    else $error("Status write did not drop the flag.");
  a_mask_stored: assert property (
    wr_mask |=> mask == $past(req.writedata[3:0]))
    else $error("Mask write not stored.");
  a_cfg_readback: assert property (
    req.read && avs_waitrequest_out && req.address == `GWIC_ADDR_CFG
      |=> avs_readdata_out[`GWIC_CFG_W-1:0] == $past(cfg))
    else $error("Configuration read returned a stale value.");
  a_clear_reads_zero: assert property (
    req.read && avs_waitrequest_out && req.address == `GWIC_ADDR_CLR
      |=> avs_readdata_out == `GWIC_RD_ZERO)
    else $error("Clear register did not read as zero.");
  a_disable_all_quiet: assert property (
    wr_cfg && req.byteenable[1:0] == 2'h3
      && (req.writedata[`GWIC_CFG_W-1:0] & `GWIC_EN_MASK) == '0
      |=> !wake_out && !irq_out && line_flags_out == '0)
    else $error("Disabled lines still flagged or woke the device.");
  a_irq_needs_flag: assert property (
    irq_out |-> |(line_flags_out & $past(mask)))
    else $error("Interrupt raised with no unmasked flag set.");

  c_cfg_written: cover property (wr_cfg);
  c_irq_raised:  cover property (!irq_out ##1 irq_out);
  c_flag_clear:  cover property (wr_clr && |flags ##1 flags == '0);
  c_wake_level:  cover property (|hits ##1 wake_out ##1 wake_out);

endmodule : gwic_top

// ### hw/gwic_defines.svh
// Address map, field layout, reset values and mode codes of the wake block.
`ifndef GWIC_DEFINES_SVH
`define GWIC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define GWIC_ADDR_CFG      12'ha24
`define GWIC_ADDR_CLR      12'ha30
`define GWIC_ADDR_STAT     12'ha40
`define GWIC_ADDR_MASK     12'ha44

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define GWIC_NUM_LINES     4
`define GWIC_FIELD_W       4
`define GWIC_EN_OFS        3
`define GWIC_MODE_W        3
`define GWIC_CFG_W         16
`define GWIC_CLR_LSB       4
`define GWIC_CFG_RST       16'h0000
`define GWIC_FLAG_RST      4'h0
`define GWIC_MASK_RST      4'h0
`define GWIC_RD_ZERO       32'h0000_0000
`define GWIC_EN_MASK       16'h8888

// ----------------------------------------------------------------------
// Trigger mode codes
// ----------------------------------------------------------------------
`define GWIC_MODE_RISE     3'h0
`define GWIC_MODE_FALL     3'h1
`define GWIC_MODE_BOTH     3'h2
`define GWIC_MODE_HIGH     3'h3
`define GWIC_MODE_LOW      3'h4
`define GWIC_MODE_FALL_A   3'h5
`define GWIC_MODE_BOTH_A   3'h6
`define GWIC_MODE_HIGH_A   3'h7

`endif

// ### hw/gwic_pkg.sv
// Types shared by the wake and interrupt configuration block.
package gwic_pkg;

  // Decoded trigger kind, one bit per kind.
  typedef enum logic [4:0] {
    GWIC_TRIG_RISE = 5'h01,
    GWIC_TRIG_FALL = 5'h02,
    GWIC_TRIG_BOTH = 5'h04,
    GWIC_TRIG_HIGH = 5'h08,
    GWIC_TRIG_LOW  = 5'h10
  } gwic_trig_e;

  // Configuration of one line as it sits in the register.
  typedef struct packed {
    logic       enable;
    logic [2:0] mode;
  } gwic_line_cfg_s;

  // One Avalon request as seen by the slave.
  typedef struct packed {
    logic        read;
    logic        write;
    logic [11:0] address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } gwic_av_req_s;

endpackage : gwic_pkg

// ### hw/gwic_line_detect.sv
// Pin synchroniser and trigger detector for one external line.
`include "gwic_defines.svh"

module gwic_line_detect
  import gwic_pkg::*;
(
  input  wire logic           ref_clk_in,
  input  wire logic           rst_n_in,
  input  wire logic           pin_in,
  input  wire gwic_line_cfg_s cfg_in,
  output logic                hit_out
);

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  function automatic gwic_trig_e decode_mode(input logic [2:0] mode);
    case (mode)
      `GWIC_MODE_RISE:   decode_mode = GWIC_TRIG_RISE;
      `GWIC_MODE_FALL:   decode_mode = GWIC_TRIG_FALL;
      `GWIC_MODE_BOTH:   decode_mode = GWIC_TRIG_BOTH;
      `GWIC_MODE_HIGH:   decode_mode = GWIC_TRIG_HIGH;
      `GWIC_MODE_LOW:    decode_mode = GWIC_TRIG_LOW;
      `GWIC_MODE_FALL_A: decode_mode = GWIC_TRIG_FALL;
      `GWIC_MODE_BOTH_A: decode_mode = GWIC_TRIG_BOTH;
      `GWIC_MODE_HIGH_A: decode_mode = GWIC_TRIG_HIGH;
      default:           decode_mode = GWIC_TRIG_RISE;
    endcase
  endfunction : decode_mode

  // ----------------------------------------------------------------------
  // Synchroniser and previous sample
  // ----------------------------------------------------------------------
  logic       pin_meta;
  logic       pin_sync;
  logic       pin_prev;
  gwic_trig_e trig;
  logic       rise;
  logic       fall;

  // The first stage feeds only the second one, never the detector.
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Trigger match
  // ----------------------------------------------------------------------
  assign trig = decode_mode(cfg_in.mode);
  assign rise = pin_sync & ~pin_prev;
  assign fall = ~pin_sync & pin_prev;

  always_comb
  begin
    hit_out = 1'b0;
    if (cfg_in.enable)
    begin
      case (trig)
        GWIC_TRIG_RISE: hit_out = rise;
        GWIC_TRIG_FALL: hit_out = fall;
        GWIC_TRIG_BOTH: hit_out = rise | fall;
        GWIC_TRIG_HIGH: hit_out = pin_sync;
        GWIC_TRIG_LOW:  hit_out = ~pin_sync;
        default:        hit_out = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_disabled_quiet: assert property (!cfg_in.enable |-> !hit_out)
    else $error("Disabled line raised a hit.");
  a_sync_two_stage: assert property (
    $past(rst_n_in, 2) && $past(rst_n_in) |-> pin_sync == $past(pin_in, 2))
    else $error("Pin did not pass two synchroniser stages.");
  a_rise_detect: assert property (
    cfg_in.enable && cfg_in.mode == `GWIC_MODE_RISE
      && pin_sync && $past(pin_sync) == 1'b0 && $past(rst_n_in)
      |-> hit_out)
    else $error("Rising edge missed.");
  a_fall_alias: assert property (
    cfg_in.enable && cfg_in.mode == `GWIC_MODE_FALL_A && hit_out
      |-> !pin_sync && pin_prev)
    else $error("Falling alias matched a non-falling sample.");
  a_level_low: assert property (
    cfg_in.enable && cfg_in.mode == `GWIC_MODE_LOW |-> hit_out == !pin_sync)
    else $error("Low level mode mismatch.");
  a_high_alias: assert property (
    cfg_in.enable && cfg_in.mode == `GWIC_MODE_HIGH_A |-> hit_out == pin_sync)
    else $error("High level alias mismatch.");

  c_both_edge: cover property (
    cfg_in.enable && cfg_in.mode == `GWIC_MODE_BOTH && fall && hit_out);

endmodule : gwic_line_detect

// ### tb/gwic_pin_model.sv
// Behavioural model of the external signals on pins 4 to 7.
module gwic_pin_model
(
  input  wire logic       ref_clk_in,
  input  wire logic [3:0] level_in,
  output logic      [3:0] pins_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Levels move just after an edge, so the synchroniser sees a full period.
  always_ff @(posedge ref_clk_in)
  begin
    pins_out <= level_in;
  end
endmodule : gwic_pin_model

// ### tb/gwic_top_test.sv
// Self-checking bench for the wake and interrupt configuration block.
`include "gwic_defines.svh"
module gwic_top_test
  import gwic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        ref_clk = 1'b0;
  logic        rst_n;
  logic [11:0] address;
  logic        read_req;
  logic        write_req;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  pin_level;
  logic [3:0]  pins;
  logic [3:0]  flags;
  logic        wake;
  logic        irq;
  logic [31:0] rd;
  int          mismatches = 0;
  int          checks_done = 0;

  always #2 ref_clk = ~ref_clk;

  gwic_pin_model i_pins (.ref_clk_in(ref_clk), .level_in(pin_level),
                         .pins_out(pins));

  gwic_top i_dut (
    .ref_clk_in(ref_clk), .rst_n_in(rst_n), .avs_address_in(address),
    .avs_read_in(read_req), .avs_write_in(write_req),
    .avs_byteenable_in(4'hf), .avs_writedata_in(writedata),
    .avs_readdata_out(readdata), .avs_waitrequest_out(waitrequest),
    .gpio_pins_in(pins), .line_flags_out(flags), .wake_out(wake),
    .irq_out(irq));

  // ----------------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------------
  task automatic compare_reg(input logic [31:0] got, input logic [31:0] exp,
                             input string what);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : compare_reg

  task automatic compare_pins(input logic [3:0] got, input logic [3:0] exp,
                              input string what);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : compare_pins

  // Holds the request until waitrequest is seen low at a rising edge.
  task automatic bus_access(input logic wr, input logic [11:0] addr,
                            input logic [31:0] data);
    @(posedge ref_clk);
    address   <= addr;
    writedata <= data;
    write_req <= wr;
    read_req  <= !wr;
    // A slave that never answers is caught by the watchdog.
    do
    begin
      @(posedge ref_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    write_req <= 1'b0;
    read_req  <= 1'b0;
  endtask : bus_access

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_cycles

  function automatic logic expect_hit(input logic [2:0] mode,
                                      input logic a, input logic b);
    case (mode)
      3'h0:       return !a & b;
      3'h1, 3'h5: return a & !b;
      3'h2, 3'h6: return a ^ b;
      3'h3, 3'h7: return a | b;
      3'h4:       return !a | !b;
      default:    return 1'b0;
    endcase
  endfunction : expect_hit

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic test_reset();
    bus_access(1'b0, `GWIC_ADDR_CFG, 32'h0);
    compare_reg(rd, 32'h0000_0000, "cfg reset");
    bus_access(1'b0, `GWIC_ADDR_MASK, 32'h0);
    compare_reg(rd, 32'h0000_0000, "mask reset");
    bus_access(1'b0, `GWIC_ADDR_STAT, 32'h0);
    compare_reg(rd, 32'h0000_0000, "status reset");
    bus_access(1'b1, 12'ha28, 32'hffff_ffff);
    bus_access(1'b0, 12'ha28, 32'h0);
    compare_reg(rd, 32'h0000_0000, "unmapped read");
    bus_access(1'b0, `GWIC_ADDR_CFG, 32'h0);
    compare_reg(rd, 32'h0000_0000, "cfg after stray write");
    compare_pins(flags, 4'h0, "flags after reset");
    compare_pins({2'h0, wake, irq}, 4'h0, "wake irq after reset");
    $display("test reset done");
  endtask : test_reset

  // Every line, enable value, mode code and pin pattern in turn.
  task automatic test_modes();
    logic [31:0] cfg;
    logic        a;
    logic        b;
    logic        hit;
    for (int ln = 0; ln < 4; ln++)
      for (int en = 0; en < 2; en++)
        for (int md = 0; md < 8; md++)
        begin
          cfg = {28'h0, en[0], md[2:0]} << (4 * ln);
          for (int ab = 0; ab < 4; ab++)
          begin
            a = ab[1];
            b = ab[0];
            bus_access(1'b1, `GWIC_ADDR_CFG, 32'h0);
            pin_level[ln] <= a;
            wait_cycles(6);
            compare_pins(flags, 4'h0, "flag dropped by disable");
            bus_access(1'b1, `GWIC_ADDR_CFG, cfg);
            pin_level[ln] <= b;
            wait_cycles(8);
            hit = en[0] & expect_hit(md[2:0], a, b);
            compare_pins(flags, 4'(hit) << ln, "line flag");
            compare_pins({3'h0, wake}, {3'h0, hit}, "wake");
            compare_pins({3'h0, irq}, 4'h0, "irq while masked");
          end
          bus_access(1'b0, `GWIC_ADDR_CFG, 32'h0);
          compare_reg(rd, cfg, "cfg readback");
        end
    $display("test modes done");
  endtask : test_modes

  task automatic test_irq();
    pin_level <= 4'h0;
    bus_access(1'b1, `GWIC_ADDR_CFG, 32'h0000_0080);
    wait_cycles(6);
    pin_level[1] <= 1'b1;
    wait_cycles(8);
    compare_pins(flags, 4'h2, "line 5 rise");
    compare_pins({2'h0, wake, irq}, 4'h2, "wake no irq");
    bus_access(1'b1, `GWIC_ADDR_MASK, 32'h2);
    wait_cycles(2);
    compare_pins({3'h0, irq}, 4'h1, "irq unmasked");
    bus_access(1'b0, `GWIC_ADDR_STAT, 32'h0);
    compare_reg(rd, 32'h2, "status");
    bus_access(1'b1, `GWIC_ADDR_CLR, 32'h20);
    wait_cycles(2);
    compare_pins({flags[1], irq, wake, 1'b0}, 4'h0, "after clear");
    bus_access(1'b0, `GWIC_ADDR_CLR, 32'h0);
    compare_reg(rd, 32'h0, "clear bit returns to zero");
    pin_level[1] <= 1'b0;
    wait_cycles(6);
    pin_level[1] <= 1'b1;
    wait_cycles(8);
    compare_pins(flags, 4'h2, "second rise");
    bus_access(1'b1, `GWIC_ADDR_STAT, 32'h2);
    wait_cycles(2);
    compare_pins({flags[1], irq, wake, 1'b0}, 4'h0, "after status clear");
    bus_access(1'b0, `GWIC_ADDR_MASK, 32'h0);
    compare_reg(rd, 32'h2, "mask readback");
    $display("test irq done");
  endtask : test_irq

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    rst_n     = 1'b0;
    address   = 12'h0;
    read_req  = 1'b0;
    write_req = 1'b0;
    writedata = 32'h0;
    pin_level = 4'h0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    test_reset();
    test_modes();
    test_irq();
    print_verdict();
  end

  // The mode sweep needs about 5300 cycles; this bound leaves ample slack.
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule : gwic_top_test
